// file: spx_ev_if.sv
`timescale 1ns/1ps
`default_nettype none
interface spx_ev_if #(parameter int W = 8);
   logic vld;
   logic [W-1:0] dat;
   modport src (output vld, output dat);
   modport snk (input vld, input dat);
endinterface: spx_ev_if
`default_nettype wire

// file: spx_io_core.sv
// Contract
// - all pins start as inputs, drivers off
// - eight-bit direction register written per pin
// - separate input and output registers per pin
// - polarity bit inverts input register read value
// - output, polarity and direction registers read back their contents
// - reset loads defaults, bus engine idles
// - alert when input differs from captured value
// - alert is active low open drain
// - three straps form low address bits
// - input pins have both drivers off
// - output pins drive high or low side
// - outputs hold last written level
// - command byte low bits select register
// - address byte bit zero selects read
// - output reads return flip-flops, not pins
// - writes to input register are ignored
`timescale 1ns/1ps
`default_nettype none
module spx_io_core
   import spx_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic link_clock,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_b,
   input wire logic addr_strap_bit0,
   input wire logic addr_strap_bit1,
   input wire logic addr_strap_bit2,
   input wire logic [7:0] port_pin_i,
   output logic [7:0] port_pin_o,
   output logic [7:0] port_pin_oe_b,
   output logic [7:0] high_side_driver,
   output logic [7:0] low_side_driver,
   output logic alert_o,
   output logic alert_oe_b
);
   spx_core_s c_q;
   spx_core_s c_d;
   spx_link_s l_q;
   spx_link_s l_d;

   logic [7:0] pins_s;
   logic lrst_b;
   logic scl_s;
   logic sda_s;
   logic [2:0] strap_s;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic mism;

   spx_ev_if #(.W(SPX_WR_W)) wr_up();
   spx_ev_if #(.W(SPX_WR_W)) wr_dn();
   spx_ev_if #(.W(SPX_IDX_W)) rq_up();
   spx_ev_if #(.W(SPX_IDX_W)) rq_dn();
   spx_ev_if #(.W(SPX_DAT_W)) rs_up();
   spx_ev_if #(.W(SPX_DAT_W)) rs_dn();

   // port pins into the core clock, running through reset
   // so the reference taken at release sees real levels
   spx_sync #(.N(SPX_PINS)) u_pin_sync (
      .clock(clock),
      .rst_b(1'b1),
      .d(port_pin_i),
      .q(pins_s)
   );

   // reset carried into the link domain
   spx_sync #(.N(1)) u_rst_sync (
      .clock(link_clock),
      .rst_b(1'b1),
      .d(rst_b),
      .q(lrst_b)
   );

   spx_sync #(.N(5)) u_bus_sync (
      .clock(link_clock),
      .rst_b(lrst_b),
      .d({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0, scl_i, sda_i}),
      .q({strap_s, scl_s, sda_s})
   );

   spx_xfer #(.W(SPX_WR_W)) u_wr_xfer (
      .src_clock(link_clock),
      .src_rst_b(lrst_b),
      .dst_clock(clock),
      .dst_rst_b(rst_b),
      .up(wr_up),
      .dn(wr_dn)
   );

   spx_xfer #(.W(SPX_IDX_W)) u_rq_xfer (
      .src_clock(link_clock),
      .src_rst_b(lrst_b),
      .dst_clock(clock),
      .dst_rst_b(rst_b),
      .up(rq_up),
      .dn(rq_dn)
   );

   spx_xfer #(.W(SPX_DAT_W)) u_rs_xfer (
      .src_clock(clock),
      .src_rst_b(rst_b),
      .dst_clock(link_clock),
      .dst_rst_b(lrst_b),
      .up(rs_up),
      .dn(rs_dn)
   );

   assign wr_up.vld = l_q.wr_v;
   assign wr_up.dat = l_q.wr_dat;
   assign rq_up.vld = l_q.rq_v;
   assign rq_up.dat = l_q.rq_idx;
   assign rs_up.vld = c_q.rs_v;
   assign rs_up.dat = c_q.rs_dat;

   // ---------------- core domain: registers and port pins
   assign mism = c_q.primed & (|((pins_s ^ c_q.inp) & c_q.dir));

   always_comb begin
      c_d = c_q;
      c_d.rs_v = 1'b0;
      // first sample after reset becomes the reference level
      if (!c_q.primed) begin
         c_d.inp = pins_s;
         c_d.primed = 1'b1;
      end
      if (wr_dn.vld) begin
         case (wr_dn.dat[SPX_WR_IDX_LSB +: SPX_IDX_W])
            SPX_REG_OUT: begin
               c_d.out = wr_dn.dat[SPX_DAT_W-1:0];
            end
            SPX_REG_POL: begin
               c_d.pol = wr_dn.dat[SPX_DAT_W-1:0];
            end
            SPX_REG_DIR: begin
               c_d.dir = wr_dn.dat[SPX_DAT_W-1:0];
            end
            default: begin
               c_d.inp = c_d.inp;
            end
         endcase
      end
      if (rq_dn.vld) begin
         c_d.rs_v = 1'b1;
         case (rq_dn.dat)
            SPX_REG_IN: begin
               c_d.rs_dat = pins_s ^ c_q.pol;
               c_d.inp = pins_s;
            end
            SPX_REG_OUT: begin
               c_d.rs_dat = c_q.out;
            end
            SPX_REG_POL: begin
               c_d.rs_dat = c_q.pol;
            end
            default: begin
               c_d.rs_dat = c_q.dir;
            end
         endcase
      end
      c_d.hi = ~c_d.dir & c_d.out;
      c_d.lo = ~c_d.dir & ~c_d.out;
      c_d.alert = mism;
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         c_q <= SPX_CORE_RST;
      end else begin
         c_q <= c_d;
      end
   end

   assign high_side_driver = c_q.hi;
   assign low_side_driver = c_q.lo;
   assign port_pin_o = c_q.hi;
   assign port_pin_oe_b = ~(c_q.hi | c_q.lo);
   assign alert_o = 1'b0;
   assign alert_oe_b = ~c_q.alert;

   // ---------------- link domain: two-wire slave engine
   assign rise = scl_s & ~l_q.scl_p;
   assign fall = ~scl_s & l_q.scl_p;
   assign start = scl_s & l_q.scl_p & l_q.sda_p & ~sda_s;
   assign stop = scl_s & l_q.scl_p & ~l_q.sda_p & sda_s;

   always_comb begin
      l_d = l_q;
      l_d.wr_v = 1'b0;
      l_d.rq_v = 1'b0;
      l_d.scl_p = scl_s;
      l_d.sda_p = sda_s;
      if (rs_dn.vld) begin
         l_d.tx = rs_dn.dat;
      end
      if (start) begin
         l_d.st = SPX_ADDR;
         l_d.cnt = SPX_CNT_ZERO;
         l_d.drv = 1'b0;
         l_d.adr = strap_s;
      end else if (stop) begin
         l_d.st = SPX_IDLE;
         l_d.drv = 1'b0;
      end else begin
         case (l_q.st)
            SPX_ADDR, SPX_CMD, SPX_WDAT: begin
               if (rise) begin
                  l_d.sh = {l_q.sh[6:0], sda_s};
                  l_d.cnt = l_q.cnt + SPX_CNT_ONE;
               end
               if (fall && l_q.cnt == SPX_BITS) begin
                  l_d.cnt = SPX_CNT_ZERO;
                  l_d.drv = 1'b1;
                  case (l_q.st)
                     SPX_ADDR: begin
                        if (l_q.sh[7:1] == {SPX_ADDR_FIXED, l_q.adr}) begin
                           l_d.rw = l_q.sh[0];
                           l_d.rq_v = l_q.sh[0];
                           l_d.rq_idx = l_q.ptr;
                           l_d.st = SPX_AACK;
                        end else begin
                           l_d.drv = 1'b0;
                           l_d.st = SPX_IDLE;
                        end
                     end
                     SPX_CMD: begin
                        l_d.ptr = l_q.sh[1:0];
                        l_d.st = SPX_CACK;
                     end
                     default: begin
                        l_d.wr_v = 1'b1;
                        l_d.wr_dat = {l_q.ptr, l_q.sh};
                        l_d.st = SPX_WACK;
                     end
                  endcase
               end
            end
            SPX_AACK, SPX_CACK, SPX_WACK: begin
               if (fall) begin
                  l_d.drv = 1'b0;
                  if (l_q.st == SPX_AACK && l_q.rw) begin
                     l_d.st = SPX_RDAT;
                     l_d.drv = ~l_q.tx[7];
                     l_d.sh = {l_q.tx[6:0], 1'b0};
                     l_d.cnt = SPX_CNT_ONE;
                  end else if (l_q.st == SPX_AACK) begin
                     l_d.st = SPX_CMD;
                  end else begin
                     l_d.st = SPX_WDAT;
                  end
               end
            end
            SPX_RDAT: begin
               if (fall) begin
                  if (l_q.cnt == SPX_BITS) begin
                     l_d.drv = 1'b0;
                     l_d.st = SPX_RACK;
                  end else begin
                     l_d.drv = ~l_q.sh[7];
                     l_d.sh = {l_q.sh[6:0], 1'b0};
                     l_d.cnt = l_q.cnt + SPX_CNT_ONE;
                  end
               end
            end
            SPX_RACK: begin
               // master ack asks for another byte of the same register
               if (rise) begin
                  if (!sda_s) begin
                     l_d.rq_v = 1'b1;
                     l_d.rq_idx = l_q.ptr;
                     l_d.st = SPX_RNXT;
                  end else begin
                     l_d.st = SPX_IDLE;
                  end
               end
            end
            SPX_RNXT: begin
               if (fall) begin
                  l_d.st = SPX_RDAT;
                  l_d.drv = ~l_q.tx[7];
                  l_d.sh = {l_q.tx[6:0], 1'b0};
                  l_d.cnt = SPX_CNT_ONE;
               end
            end
            default: begin
               l_d.drv = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge link_clock) begin
      if (!lrst_b) begin
         l_q <= SPX_LINK_RST;
      end else begin
         l_q <= l_d;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_b = ~l_q.drv;

   // ---------------- checks, core domain
   reset_dir_a: assert property (@(posedge clock) disable iff (!rst_b)
      !$past(rst_b) |-> port_pin_oe_b == SPX_ALL_OFF && c_q.dir == SPX_DIR_RST)
      else $error("pins not inputs after reset");

   wr_dir_a: assert property (@(posedge clock) disable iff (!rst_b)
      wr_dn.vld && wr_dn.dat[9:8] == SPX_REG_DIR
      |=> c_q.dir == $past(wr_dn.dat[7:0]))
      else $error("direction write lost");

   in_wr_a: assert property (@(posedge clock) disable iff (!rst_b)
      wr_dn.vld && wr_dn.dat[9:8] == SPX_REG_IN && !rq_dn.vld
      |=> $stable(c_q.out) && $stable(c_q.pol) && $stable(c_q.dir))
      else $error("input register write changed state");

   rd_out_a: assert property (@(posedge clock) disable iff (!rst_b)
      rq_dn.vld && rq_dn.dat == SPX_REG_OUT
      |=> c_q.rs_v && c_q.rs_dat == $past(c_q.out) ##1 rs_up.vld == 1'b0)
      else $error("output read not from flip-flops");

   rd_in_a: assert property (@(posedge clock) disable iff (!rst_b)
      rq_dn.vld && rq_dn.dat == SPX_REG_IN
      |=> c_q.rs_dat == ($past(pins_s) ^ $past(c_q.pol))
      && c_q.inp == $past(pins_s))
      else $error("input read wrong polarity or capture");

   alert_a: assert property (@(posedge clock) disable iff (!rst_b)
      1'b1 |=> alert_oe_b == !$past(mism))
      else $error("alert does not follow input change");

   drive_a: assert property (@(posedge clock) disable iff (!rst_b)
      (high_side_driver | low_side_driver) == ~c_q.dir
      && high_side_driver == (~c_q.dir & c_q.out)
      && (high_side_driver & low_side_driver) == SPX_BYTE_ZERO)
      else $error("pin drivers disagree with direction");

   hold_out_a: assert property (@(posedge clock) disable iff (!rst_b)
      !(wr_dn.vld && wr_dn.dat[9:8] == SPX_REG_OUT) |=> $stable(c_q.out))
      else $error("output latch changed without write");

   pin_sync_a: assert property (@(posedge clock) disable iff (!rst_b)
      $past(rst_b) && $past(rst_b, 2) |-> pins_s == $past(port_pin_i, 2))
      else $error("pin sample not two stages late");

   // ---------------- checks, link domain
   sequence addr_hit_s;
      l_q.st == SPX_ADDR && fall && l_q.cnt == SPX_BITS
      && l_q.sh[7:1] == {SPX_ADDR_FIXED, l_q.adr};
   endsequence

   sequence cmd_done_s;
      l_q.st == SPX_CMD && fall && l_q.cnt == SPX_BITS;
   endsequence

   property addr_ack_p;
      @(posedge link_clock) disable iff (!lrst_b)
      addr_hit_s |=> l_q.drv && !sda_oe_b && l_q.st == SPX_AACK;
   endproperty

   property read_req_p;
      @(posedge link_clock) disable iff (!lrst_b)
      addr_hit_s ##0 l_q.sh[0] |=> l_q.rq_v && l_q.rq_idx == l_q.ptr;
   endproperty

   property cmd_ptr_p;
      @(posedge link_clock) disable iff (!lrst_b)
      cmd_done_s |=> l_q.ptr == $past(l_q.sh[1:0]) ##1 !l_q.wr_v;
   endproperty

   addr_ack_a: assert property (addr_ack_p) else $error("address not acked");
   read_req_a: assert property (read_req_p) else $error("read not requested");
   cmd_ptr_a: assert property (cmd_ptr_p) else $error("command not stored");
endmodule: spx_io_core
`default_nettype wire

// file: spx_master.sv
`timescale 1ns/1ps
`default_nettype none
module spx_master (
   input wire logic lclk,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   // clock stands high and data is released between frames
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic q(input int n);
      repeat (n) @(posedge lclk);
      #1;
   endtask: q

   // low phase of 16 link cycles leaves room for read data fetch
   task automatic bit_out(input logic b);
      q(8);
      sda_o = b;
      q(8);
      scl_o = 1'b1;
      q(8);
      scl_o = 1'b0;
   endtask: bit_out

   task automatic bit_in(output logic b);
      q(8);
      sda_o = 1'b1;
      q(8);
      scl_o = 1'b1;
      q(4);
      b = sda_i;
      q(4);
      scl_o = 1'b0;
   endtask: bit_in

   // also serves as repeated start from a low clock
   task automatic bus_start();
      q(8);
      sda_o = 1'b1;
      q(8);
      scl_o = 1'b1;
      q(8);
      sda_o = 1'b0;
      q(8);
      scl_o = 1'b0;
   endtask: bus_start

   task automatic bus_stop();
      q(8);
      sda_o = 1'b0;
      q(8);
      scl_o = 1'b1;
      q(8);
      sda_o = 1'b1;
      q(8);
   endtask: bus_stop

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) bit_out(d[i]);
      bit_in(b);
      ack = ~b;
   endtask: wr_byte

   task automatic rd_byte(input logic more, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) bit_in(d[i]);
      bit_out(~more);
   endtask: rd_byte
endmodule: spx_master
`default_nettype wire

// file: spx_pkg.sv
`default_nettype none
package spx_pkg;
   localparam int SPX_PINS = 8;
   localparam int SPX_IDX_W = 2;
   localparam int SPX_DAT_W = 8;
   localparam int SPX_WR_W = SPX_IDX_W + SPX_DAT_W;
   localparam int SPX_WR_IDX_LSB = SPX_DAT_W;

   // command byte low bits select the register
   localparam logic [1:0] SPX_REG_IN = 2'h0;
   localparam logic [1:0] SPX_REG_OUT = 2'h1;
   localparam logic [1:0] SPX_REG_POL = 2'h2;
   localparam logic [1:0] SPX_REG_DIR = 2'h3;

   localparam logic [7:0] SPX_OUT_RST = 8'hff;
   localparam logic [7:0] SPX_POL_RST = 8'h00;
   localparam logic [7:0] SPX_DIR_RST = 8'hff;
   localparam logic [7:0] SPX_BYTE_ZERO = 8'h00;
   localparam logic [7:0] SPX_ALL_OFF = 8'hff;

   // upper address nibble, straps fill the next three bits
   localparam logic [3:0] SPX_ADDR_FIXED = 4'h4;
   localparam logic [3:0] SPX_BITS = 4'h8;
   localparam logic [3:0] SPX_CNT_ZERO = 4'h0;
   localparam logic [3:0] SPX_CNT_ONE = 4'h1;

   typedef enum logic [3:0] {
      SPX_IDLE,
      SPX_ADDR,
      SPX_AACK,
      SPX_CMD,
      SPX_CACK,
      SPX_WDAT,
      SPX_WACK,
      SPX_RDAT,
      SPX_RACK,
      SPX_RNXT
   } spx_link_e;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] pol;
      logic [7:0] dir;
      logic [7:0] inp;
      logic primed;
      logic alert;
      logic [7:0] hi;
      logic [7:0] lo;
      logic rs_v;
      logic [7:0] rs_dat;
   } spx_core_s;

   typedef struct packed {
      spx_link_e st;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic rw;
      logic [1:0] ptr;
      logic drv;
      logic [7:0] tx;
      logic scl_p;
      logic sda_p;
      logic [2:0] adr;
      logic wr_v;
      logic [9:0] wr_dat;
      logic rq_v;
      logic [1:0] rq_idx;
   } spx_link_s;

   localparam spx_core_s SPX_CORE_RST = '{
      out: SPX_OUT_RST, pol: SPX_POL_RST, dir: SPX_DIR_RST,
      inp: SPX_BYTE_ZERO, primed: 1'b0, alert: 1'b0,
      hi: SPX_BYTE_ZERO, lo: SPX_BYTE_ZERO, rs_v: 1'b0,
      rs_dat: SPX_BYTE_ZERO};

   localparam spx_link_s SPX_LINK_RST = '{
      st: SPX_IDLE, sh: SPX_BYTE_ZERO, cnt: SPX_CNT_ZERO, rw: 1'b0,
      ptr: SPX_REG_IN, drv: 1'b0, tx: SPX_BYTE_ZERO, scl_p: 1'b0,
      sda_p: 1'b0, adr: 3'h0, wr_v: 1'b0, wr_dat: 10'h000, rq_v: 1'b0,
      rq_idx: SPX_REG_IN};
endpackage: spx_pkg
`default_nettype wire

// file: spx_sync.sv
`timescale 1ns/1ps
`default_nettype none
module spx_sync #(parameter int N = 1) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [N-1:0] d,
   output logic [N-1:0] q
);
   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
   } spx_sync_s;

   spx_sync_s r_q;
   spx_sync_s r_d;

   always_comb begin
      r_d.s1 = d;
      r_d.s2 = r_q.s1;
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign q = r_q.s2;
endmodule: spx_sync
`default_nettype wire

// file: spx_xfer.sv
`timescale 1ns/1ps
`default_nettype none
module spx_xfer #(parameter int W = 8) (
   input wire logic src_clock,
   input wire logic src_rst_b,
   input wire logic dst_clock,
   input wire logic dst_rst_b,
   spx_ev_if.snk up,
   spx_ev_if.src dn
);
   typedef struct packed {
      logic tg;
      logic [W-1:0] dat;
   } spx_xsrc_s;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic vld;
      logic [W-1:0] dat;
   } spx_xdst_s;

   spx_xsrc_s s_q;
   spx_xsrc_s s_d;
   spx_xdst_s d_q;
   spx_xdst_s d_d;

   // toggle carries the event, data held stable until the next one
   always_comb begin
      s_d = s_q;
      if (up.vld) begin
         s_d.tg = ~s_q.tg;
         s_d.dat = up.dat;
      end
   end

   always_ff @(posedge src_clock) begin
      if (!src_rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   always_comb begin
      d_d = d_q;
      d_d.s1 = s_q.tg;
      d_d.s2 = d_q.s1;
      d_d.s3 = d_q.s2;
      d_d.vld = d_q.s2 ^ d_q.s3;
      if (d_q.s2 ^ d_q.s3) begin
         d_d.dat = s_q.dat;
      end
   end

   always_ff @(posedge dst_clock) begin
      if (!dst_rst_b) begin
         d_q <= '0;
      end else begin
         d_q <= d_d;
      end
   end

   assign dn.vld = d_q.vld;
   assign dn.dat = d_q.dat;

   xfer_pulse_a: assert property (@(posedge dst_clock) disable iff (!dst_rst_b)
      dn.vld |=> !dn.vld) else $error("crossed event longer than a cycle");
endmodule: spx_xfer
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import spx_pkg::*;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic link_clock = 1'b0;
   logic [2:0] strap = 3'h0;
   logic [7:0] ext = 8'hff;
   logic scl_m, sda_m, sda_o, sda_oe_b, alert_o, alert_oe_b, sda_w;
   logic [7:0] pin_o, pin_oe_b, hs, ls, pin_w;
   int n_mismatch = 0;
   int num_checks = 0;

   always #25 clock = ~clock;
   initial begin
      #13;
      forever #40 link_clock = ~link_clock;
   end

   // wired bus with pull-up; pins show driver level or outside level
   assign sda_w = sda_m & (sda_oe_b | sda_o);
   assign pin_w = (pin_oe_b & ext) | (~pin_oe_b & pin_o);

   spx_io_core dut (.clock(clock), .rst_b(rst_b), .link_clock(link_clock),
      .scl_i(scl_m), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_b(sda_oe_b),
      .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
      .addr_strap_bit2(strap[2]), .port_pin_i(pin_w), .port_pin_o(pin_o),
      .port_pin_oe_b(pin_oe_b), .high_side_driver(hs),
      .low_side_driver(ls), .alert_o(alert_o), .alert_oe_b(alert_oe_b));
   spx_master m (.lclk(link_clock), .sda_i(sda_w), .scl_o(scl_m),
      .sda_o(sda_m));

   task automatic end_sim();
      if (n_mismatch == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask: end_sim

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask: chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask: cyc

   task automatic reg_wr(input logic [7:0] cmd, input logic [7:0] d);
      logic a0, a1, a2;
      m.bus_start();
      m.wr_byte({SPX_ADDR_FIXED, strap, 1'b0}, a0);
      m.wr_byte(cmd, a1);
      m.wr_byte(d, a2);
      m.bus_stop();
      chk({5'h00, a0, a1, a2}, 8'h07);
   endtask: reg_wr

   task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
      logic a0, a1, a2;
      logic [7:0] d;
      m.bus_start();
      m.wr_byte({SPX_ADDR_FIXED, strap, 1'b0}, a0);
      m.wr_byte(cmd, a1);
      m.bus_start();
      m.wr_byte({SPX_ADDR_FIXED, strap, 1'b1}, a2);
      m.rd_byte(1'b0, d);
      m.bus_stop();
      chk({5'h00, a0, a1, a2}, 8'h07);
      chk(d, exp);
   endtask: rd_chk

   task automatic wait_alert(input logic v);
      for (int k = 0; k < 10 && alert_oe_b !== v; k++) cyc(1);
      chk({7'h00, alert_oe_b}, {7'h00, v});
   endtask: wait_alert

   task automatic t_defaults();
      chk(pin_oe_b, 8'hff);
      chk(hs | ls, 8'h00);
      chk({6'h00, alert_oe_b, sda_oe_b}, 8'h03);
      rd_chk(8'h01, 8'hff);
      rd_chk(8'h02, 8'h00);
      rd_chk(8'h03, 8'hff);
   endtask: t_defaults

   task automatic t_straps();
      logic a;
      for (int s = 0; s < 8; s++) begin
         strap = s[2:0];
         m.bus_start();
         m.wr_byte({SPX_ADDR_FIXED, strap, 1'b0}, a);
         m.bus_stop();
         chk({7'h00, a}, 8'h01);
         m.bus_start();
         m.wr_byte({SPX_ADDR_FIXED, ~strap, 1'b0}, a);
         m.bus_stop();
         chk({7'h00, a}, 8'h00);
      end
   endtask: t_straps

   task automatic t_outputs();
      reg_wr(8'h03, 8'hf0);
      reg_wr(8'h01, 8'h5a);
      cyc(2);
      chk(pin_oe_b, 8'hf0);
      chk(hs, 8'h0a);
      chk(ls, 8'h05);
      chk(pin_o & ~pin_oe_b, 8'h0a);
      rd_chk(8'h01, 8'h5a);
      reg_wr(8'h00, 8'h00);
      rd_chk(8'h01, 8'h5a);
      rd_chk(8'h03, 8'hf0);
      chk(hs, 8'h0a);
   endtask: t_outputs

   task automatic t_polarity();
      ext = 8'h3c;
      reg_wr(8'hfe, 8'ha0);
      rd_chk(8'h02, 8'ha0);
      rd_chk(8'h00, 8'h9a);
   endtask: t_polarity

   task automatic t_alert();
      chk({7'h00, alert_oe_b}, 8'h01);
      chk({7'h00, alert_o}, 8'h00);
      ext = 8'h1c;
      cyc(1);
      chk({7'h00, alert_oe_b}, 8'h01);
      wait_alert(1'b0);
      ext = 8'h3c;
      wait_alert(1'b1);
      ext = 8'h7c;
      wait_alert(1'b0);
      rd_chk(8'h00, 8'hda);
      chk({7'h00, alert_oe_b}, 8'h01);
   endtask: t_alert

   task automatic t_reset();
      logic a;
      logic [7:0] d0, d1;
      cyc(1);
      rst_b = 1'b0;
      cyc(12);
      chk(pin_oe_b, 8'hff);
      chk(hs | ls, 8'h00);
      rst_b = 1'b1;
      cyc(12);
      chk({7'h00, alert_oe_b}, 8'h01);
      m.bus_start();
      m.wr_byte({SPX_ADDR_FIXED, strap, 1'b1}, a);
      m.rd_byte(1'b1, d0);
      m.rd_byte(1'b0, d1);
      m.bus_stop();
      chk({7'h00, a}, 8'h01);
      chk(d0, ext);
      chk(d1, ext);
      rd_chk(8'h01, 8'hff);
      rd_chk(8'h02, 8'h00);
   endtask: t_reset

   // whole sequence takes about 1.5 ms of bus traffic
   initial begin
      #3_000_000;
      n_mismatch++;
      end_sim();
   end

   initial begin
      cyc(12);
      rst_b = 1'b1;
      cyc(12);
      t_defaults();
      t_straps();
      t_outputs();
      t_polarity();
      t_alert();
      t_reset();
      end_sim();
   end
endmodule: tb_top
`default_nettype wire
